// ==== logic/ua_pkg.sv ====
package ua_pkg;

  // register bus geometry: byte address, word index is adr[7:2]
  localparam int ADR_W = 8;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQEN  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_RXCTL  = 6'h13;
  localparam logic [IDX_W-1:0] IDX_RXDATA = 6'h14;
  localparam logic [IDX_W-1:0] IDX_TXCTL  = 6'h15;
  localparam logic [IDX_W-1:0] IDX_TXHOLD = 6'h16;
  localparam logic [IDX_W-1:0] IDX_BAUD   = 6'h17;

  // tx_status_control fields
  localparam int TXC_NINE_SEL = 6;
  localparam int TXC_TX_EN    = 5;
  localparam int TXC_SYNC     = 4;
  localparam int TXC_SH_EMPTY = 1;
  localparam int TXC_NINTH    = 0;

  // rx_status_control fields
  localparam int RXC_PORT_EN  = 7;
  localparam int RXC_NINE_SEL = 6;
  localparam int RXC_SINGLE   = 5;
  localparam int RXC_CONT     = 4;
  localparam int RXC_FRAMING  = 2;
  localparam int RXC_OVERRUN  = 1;
  localparam int RXC_NINTH    = 0;

  // peripheral flag / enable fields
  localparam int FLG_TX = 1;
  localparam int FLG_RX = 0;

  // baud generator: x64 ticks, x16 every 4, bit every 64
  localparam int X16_DIV_W = 2;
  localparam int BIT_DIV_W = 6;

  // x16 sample points within a bit, counted from 1
  localparam logic [3:0] PH_EDGE   = 4'h1;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_MID   = 4'h8;
  localparam logic [3:0] SMP_LAST  = 4'h9;

  // data bit counts
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  localparam int FIFO_DEPTH = 2;

  typedef struct packed {
    logic       framing;
    logic       ninth;
    logic [7:0] data;
  } ua_rx_word_s;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } ua_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ua_wb_rsp_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_WAIT  = 3'b001,
    TX_START = 3'b011,
    TX_DATA  = 3'b010,
    TX_STOP  = 3'b110
  } ua_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } ua_rx_state_e;

endpackage : ua_pkg

// ==== logic/ua_baud.sv ====
`timescale 1ns/1ns
module ua_baud
  import ua_pkg::*;
(
  input  wire logic       sys_clk_i,  // system clock
  input  wire logic       arst_n_i,   // async reset, active low
  input  wire logic       run_i,      // generator released from reset
  input  wire logic [7:0] div_i,      // baud divisor
  output logic            x16_tick_o, // one pulse per x16 period
  output logic            bit_tick_o  // one pulse per bit period
);

  typedef struct packed {
    logic [7:0]           cnt;
    logic [BIT_DIV_W-1:0] sub;
  } ua_baud_s;

  ua_baud_s s_reg;
  ua_baud_s s_next;
  logic     x64_tick;

  // the x64 clock fires every div+1 system clocks
  assign x64_tick   = run_i && (s_reg.cnt == 8'h00);
  assign x16_tick_o = x64_tick && (&s_reg.sub[X16_DIV_W-1:0]);
  assign bit_tick_o = x64_tick && (&s_reg.sub);

  // held in reset while nothing uses it, so a fresh enable starts a full period
  always_comb begin
    s_next = s_reg;
    if (!run_i) begin
      s_next = '0;
    end else if (x64_tick) begin
      s_next.cnt = div_i;
      s_next.sub = s_reg.sub + 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ua_baud

// ==== logic/ua_rx_fifo.sv ====
`timescale 1ns/1ns
module ua_rx_fifo
  import ua_pkg::*;
(
  input  wire logic         sys_clk_i, // system clock
  input  wire logic         arst_n_i,  // async reset, active low
  input  wire logic         push_i,    // write one word
  input  ua_rx_word_s       word_i,    // word to write
  input  wire logic         pop_i,     // drop the head word
  output ua_rx_word_s       head_o,    // oldest word
  output logic              empty_o,   // nothing stored
  output logic              full_o     // no room
);

  typedef struct packed {
    ua_rx_word_s [FIFO_DEPTH-1:0] mem;
    logic                         wp;
    logic                         rp;
    logic [1:0]                   cnt;
  } ua_fifo_s;

  ua_fifo_s s_reg;
  ua_fifo_s s_next;

  assign head_o  = s_reg.mem[s_reg.rp];
  assign empty_o = (s_reg.cnt == 2'h0);
  assign full_o  = (s_reg.cnt == 2'(FIFO_DEPTH));

  // push is refused when full, pop when empty
  always_comb begin
    s_next = s_reg;
    if (push_i && !full_o) begin
      s_next.mem[s_reg.wp] = word_i;
      s_next.wp            = ~s_reg.wp;
    end
    if (pop_i && !empty_o) begin
      s_next.rp = ~s_reg.rp;
    end
    s_next.cnt = s_reg.cnt + 2'((push_i && !full_o)) - 2'((pop_i && !empty_o));
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ua_rx_fifo

// ==== logic/ua_async_top.sv ====
// Functional notes
// - frame is start, 8/9 data, stop, NRZ
// - 8-bit divisor, generator runs x64 bit rate
// - no hardware parity; ninth bit is software's
// - all async activity halts during sleep; the idle shifter still loads the holding buffer
// - sync bit clear selects async; port enable activates
// - reload shifter only after stop bit, if data
// - reload at generator period end; sets empty flag
// - empty flag clears only by holding buffer write
// - read-only shifter empty bit, no interrupt
// - shifting waits for data and a shift clock
// - empty shifter takes written data at once
// - clearing transmit enable aborts, pin floats
// - clearing port or transmit enable resets transmitter
// - receive recovery runs at x16 baud rate
// - continuous receive enable starts reception
// - after stop bit push fifo, set data flag
// - data flag clears when fifo read empty
// - two-deep fifo; third word sets overrun, lost
// - overrun blocks fifo; cleared via receive enable
// - framing flag set when stop bit missing
// - framing and ninth bit travel with data
// - majority of samples seven, eight, nine
// - receive nine-bit select; ninth bit reported
// - clearing receive or port enable resets receiver
`timescale 1ns/1ns
module ua_async_top
  import ua_pkg::*;
(
  input  wire logic  sys_clk_i,     // system clock, 25 MHz
  input  wire logic  arst_n_i,      // async reset, active low
  input  ua_wb_req_s wb_req_i,      // wishbone request from master
  output ua_wb_rsp_s wb_rsp_o,      // wishbone answer
  input  wire logic  sleep_i,       // device in low-power sleep
  input  wire logic  rx_pin_i,      // receive line, asynchronous
  output logic       tx_pin_o,      // transmit line level
  output logic       tx_pin_oe_n_o  // low while driving the line
);

  typedef struct packed {
    // bus answer
    logic               ack;
    logic [7:0]         rdat;
    // control registers
    logic               port_enable;
    logic               rx_nine_bit_select;
    logic               single_receive_enable;
    logic               continuous_receive_enable;
    logic               tx_nine_bit_select;
    logic               transmit_enable;
    logic               sync_mode;
    logic               tx_ninth_bit;
    logic [7:0]         baud_divisor;
    logic [1:0]         irq_enable;
    logic               overrun_flag;
    // transmit path
    logic [7:0]         tx_holding_buffer;
    logic               hold_ninth;
    logic               hold_full;
    ua_tx_state_e       tx_st;
    logic [8:0]         tx_shift_register;
    logic [3:0]         tx_len;
    logic [3:0]         tx_cnt;
    logic               tx_line;
    // receive path
    logic               rx_meta;
    logic               rx_sync;
    logic               rx_prev;
    ua_rx_state_e       rx_st;
    logic [3:0]         rx_ph;
    logic [1:0]         rx_votes;
    logic [8:0]         rx_shift_register;
    logic [3:0]         rx_len;
    logic [3:0]         rx_cnt;
  } ua_top_s;

  ua_top_s     s_reg;
  ua_top_s     s_next;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [IDX_W-1:0] idx;
  logic [7:0]  wbyte;
  logic        tx_active;
  logic        rx_active;
  logic        brg_run;
  logic        x16_tick;
  logic        bit_tick;
  logic        fifo_push;
  logic        fifo_pop;
  ua_rx_word_s fifo_word;
  ua_rx_word_s fifo_head;
  logic        fifo_empty;
  logic        fifo_full;
  logic        shifter_empty_flag;
  logic        tx_buffer_empty_flag;
  logic        rx_data_flag;
  logic        rx_bit;
  logic [7:0]  rd_mux;

  // bus decode: a request is taken in the cycle before ack is given
  assign bus_req = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
  assign bus_wr  = bus_req && wb_req_i.we && wb_req_i.sel[0];
  assign bus_rd  = bus_req && !wb_req_i.we;
  assign idx     = wb_req_i.adr[ADR_W-1:IDX_LSB];
  assign wbyte   = wb_req_i.dat[7:0];

  assign tx_active = s_reg.port_enable && !s_reg.sync_mode && s_reg.transmit_enable;
  assign rx_active = s_reg.port_enable && !s_reg.sync_mode
                   && (s_reg.continuous_receive_enable || s_reg.single_receive_enable);
  // generator stays in reset when unused and also in sleep
  assign brg_run   = (tx_active || rx_active) && !sleep_i;

  assign shifter_empty_flag   = (s_reg.tx_st == TX_IDLE);
  assign tx_buffer_empty_flag = !s_reg.hold_full;
  assign rx_data_flag         = !fifo_empty;

  ua_baud u_baud (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .run_i      (brg_run),
    .div_i      (s_reg.baud_divisor),
    .x16_tick_o (x16_tick),
    .bit_tick_o (bit_tick)
  );

  ua_rx_fifo u_fifo (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .push_i    (fifo_push),
    .word_i    (fifo_word),
    .pop_i     (fifo_pop),
    .head_o    (fifo_head),
    .empty_o   (fifo_empty),
    .full_o    (fifo_full)
  );

  // majority of the two stored samples and the current one
  assign rx_bit = (s_reg.rx_votes[0] & s_reg.rx_votes[1])
                | (s_reg.rx_sync & (s_reg.rx_votes[0] | s_reg.rx_votes[1]));

  // read mux; status of the fifo head must be read before its data
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_FLAGS: begin
        rd_mux[FLG_TX] = tx_buffer_empty_flag;
        rd_mux[FLG_RX] = rx_data_flag;
      end
      IDX_IRQEN: begin
        rd_mux[FLG_TX] = s_reg.irq_enable[FLG_TX];
        rd_mux[FLG_RX] = s_reg.irq_enable[FLG_RX];
      end
      IDX_RXCTL: begin
        rd_mux[RXC_PORT_EN]  = s_reg.port_enable;
        rd_mux[RXC_NINE_SEL] = s_reg.rx_nine_bit_select;
        rd_mux[RXC_SINGLE]   = s_reg.single_receive_enable;
        rd_mux[RXC_CONT]     = s_reg.continuous_receive_enable;
        rd_mux[RXC_FRAMING]  = !fifo_empty && fifo_head.framing;
        rd_mux[RXC_OVERRUN]  = s_reg.overrun_flag;
        rd_mux[RXC_NINTH]    = !fifo_empty && fifo_head.ninth;
      end
      IDX_RXDATA: rd_mux = fifo_empty ? 8'h00 : fifo_head.data;
      IDX_TXCTL: begin
        rd_mux[TXC_NINE_SEL] = s_reg.tx_nine_bit_select;
        rd_mux[TXC_TX_EN]    = s_reg.transmit_enable;
        rd_mux[TXC_SYNC]     = s_reg.sync_mode;
        rd_mux[TXC_SH_EMPTY] = shifter_empty_flag;
        rd_mux[TXC_NINTH]    = s_reg.tx_ninth_bit;
      end
      IDX_TXHOLD: rd_mux = s_reg.tx_holding_buffer;
      IDX_BAUD:   rd_mux = s_reg.baud_divisor;
      default:    rd_mux = 8'h00; // unmapped reads as zero
    endcase
  end

  // reading the data word pops the fifo and advances framing/ninth status
  assign fifo_pop = bus_rd && (idx == IDX_RXDATA);

  // one process for the whole block state
  always_comb begin
    s_next      = s_reg;
    fifo_push   = 1'b0;
    fifo_word   = '0;

    // bus answer, one wait state, ack held for one cycle only
    s_next.ack  = bus_req;
    if (bus_rd) begin
      s_next.rdat = rd_mux;
    end

    // register writes
    if (bus_wr) begin
      unique case (idx)
        IDX_IRQEN: begin
          s_next.irq_enable[FLG_TX] = wbyte[FLG_TX];
          s_next.irq_enable[FLG_RX] = wbyte[FLG_RX];
        end
        IDX_RXCTL: begin
          s_next.port_enable               = wbyte[RXC_PORT_EN];
          s_next.rx_nine_bit_select        = wbyte[RXC_NINE_SEL];
          s_next.single_receive_enable     = wbyte[RXC_SINGLE];
          s_next.continuous_receive_enable = wbyte[RXC_CONT];
        end
        IDX_TXCTL: begin
          s_next.tx_nine_bit_select = wbyte[TXC_NINE_SEL];
          s_next.transmit_enable    = wbyte[TXC_TX_EN];
          s_next.sync_mode          = wbyte[TXC_SYNC];
          s_next.tx_ninth_bit       = wbyte[TXC_NINTH];
        end
        IDX_BAUD: s_next.baud_divisor = wbyte;
        default: ;
      endcase
    end

    // ---- transmitter, steps on generator bit ticks except the load from idle
    if (!tx_active) begin
      s_next.tx_st   = TX_IDLE;
      s_next.tx_line = 1'b1;
      s_next.tx_cnt  = 4'h0;
    end else begin
      unique case (s_reg.tx_st)
        TX_IDLE: begin
          // empty shifter takes the buffer at once, freeing it for the next
          if (s_reg.hold_full) begin
            s_next.tx_shift_register = {s_reg.hold_ninth, s_reg.tx_holding_buffer};
            s_next.tx_len   = s_reg.tx_nine_bit_select ? BITS_NINE : BITS_EIGHT;
            s_next.hold_full = 1'b0;
            s_next.tx_st    = TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (bit_tick) begin
            s_next.tx_line = 1'b0;
            s_next.tx_st   = TX_START;
          end
        end
        TX_START: begin
          if (bit_tick) begin
            s_next.tx_line           = s_reg.tx_shift_register[0];
            s_next.tx_shift_register = {1'b0, s_reg.tx_shift_register[8:1]};
            s_next.tx_cnt            = 4'h1;
            s_next.tx_st             = TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_tick) begin
            if (s_reg.tx_cnt == s_reg.tx_len) begin
              s_next.tx_line = 1'b1;
              s_next.tx_st   = TX_STOP;
            end else begin
              s_next.tx_line           = s_reg.tx_shift_register[0];
              s_next.tx_shift_register = {1'b0, s_reg.tx_shift_register[8:1]};
              s_next.tx_cnt            = s_reg.tx_cnt + 4'h1;
            end
          end
        end
        TX_STOP: begin
          // reload only at the end of the stop bit, on the tick itself
          if (bit_tick) begin
            if (s_reg.hold_full) begin
              s_next.tx_shift_register = {s_reg.hold_ninth, s_reg.tx_holding_buffer};
              s_next.tx_len    = s_reg.tx_nine_bit_select ? BITS_NINE : BITS_EIGHT;
              s_next.hold_full = 1'b0;
              s_next.tx_line   = 1'b0;
              s_next.tx_st     = TX_START;
            end else begin
              s_next.tx_st = TX_IDLE;
            end
          end
        end
        default: s_next.tx_st = TX_IDLE;
      endcase
    end

    // a buffer write wins over a same-cycle reload of the shifter
    if (bus_wr && (idx == IDX_TXHOLD)) begin
      s_next.tx_holding_buffer = wbyte;
      s_next.hold_ninth        = s_reg.tx_ninth_bit;
      s_next.hold_full         = 1'b1;
    end

    // a write that drops an enable must not leave a low level behind the released pin
    if (!(s_next.port_enable && !s_next.sync_mode && s_next.transmit_enable)) begin
      s_next.tx_line = 1'b1;
    end

    // ---- receiver, two flops before any logic reads the pin
    s_next.rx_meta = rx_pin_i;
    s_next.rx_sync = s_reg.rx_meta;
    if (!rx_active) begin
      s_next.rx_st        = RX_IDLE;
      s_next.overrun_flag = 1'b0;
      s_next.rx_prev      = 1'b1;
    end else if (x16_tick) begin
      s_next.rx_prev = s_reg.rx_sync;
      s_next.rx_ph   = s_reg.rx_ph + 4'h1;
      if (s_next.rx_ph == SMP_FIRST) begin
        s_next.rx_votes[0] = s_reg.rx_sync;
      end
      if (s_next.rx_ph == SMP_MID) begin
        s_next.rx_votes[1] = s_reg.rx_sync;
      end
      unique case (s_reg.rx_st)
        RX_IDLE: begin
          if (s_reg.rx_prev && !s_reg.rx_sync) begin
            s_next.rx_ph  = PH_EDGE;
            s_next.rx_len = s_reg.rx_nine_bit_select ? BITS_NINE : BITS_EIGHT;
            s_next.rx_st  = RX_START;
          end
        end
        RX_START: begin
          if (s_next.rx_ph == SMP_LAST) begin
            s_next.rx_cnt = 4'h0;
            s_next.rx_st  = rx_bit ? RX_IDLE : RX_DATA; // false start glitch dropped
          end
        end
        RX_DATA: begin
          if (s_next.rx_ph == SMP_LAST) begin
            s_next.rx_shift_register = {rx_bit, s_reg.rx_shift_register[8:1]};
            s_next.rx_cnt            = s_reg.rx_cnt + 4'h1;
            if (s_next.rx_cnt == s_reg.rx_len) begin
              s_next.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_next.rx_ph == SMP_LAST) begin
            fifo_word.framing = !rx_bit;
            if (s_reg.rx_len == BITS_NINE) begin
              fifo_word.ninth = s_reg.rx_shift_register[8];
              fifo_word.data  = s_reg.rx_shift_register[7:0];
            end else begin
              fifo_word.data  = s_reg.rx_shift_register[8:1];
            end
            if (!s_reg.overrun_flag) begin
              if (fifo_full && !fifo_pop) begin
                s_next.overrun_flag = 1'b1;
              end else begin
                fifo_push = 1'b1;
              end
            end
            s_next.rx_st = RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg         <= '0;
      s_reg.tx_line <= 1'b1;
      s_reg.rx_meta <= 1'b1;
      s_reg.rx_sync <= 1'b1;
      s_reg.rx_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // pin floats whenever the transmitter is reset
  assign tx_pin_o      = s_reg.tx_line;
  assign tx_pin_oe_n_o = !tx_active;
  assign wb_rsp_o.ack  = s_reg.ack;
  assign wb_rsp_o.dat  = {24'h000000, s_reg.rdat};

endmodule : ua_async_top

// ==== tb/ua_async_top_props.sv ====
`timescale 1ns/1ns
module ua_async_top_props
  import ua_pkg::*;
(
  input wire logic  sys_clk_i,     // system clock
  input wire logic  arst_n_i,      // async reset, low
  input ua_wb_req_s wb_req_i,      // bus request
  input ua_wb_rsp_s wb_rsp_o,      // bus answer
  input wire logic  sleep_i,       // sleep level
  input wire logic  rx_pin_i,      // receive line
  input wire logic  tx_pin_o,      // transmit level
  input wire logic  tx_pin_oe_n_o  // drive enable, low
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // acked write that drops transmit enable
  logic tx_off;
  assign tx_off = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
    && wb_req_i.adr == {IDX_TXCTL, 2'b00} && !wb_req_i.dat[TXC_TX_EN];

  // bus answers: one wait state, one cycle wide, never unasked
  chk_ack_single:
    assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack too long");
  chk_ack_wait:
    assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("ack late");
  chk_ack_cause:
    assert property ($rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  chk_read_upper:
    assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
    else $error("upper data bits set");
  // serial line shape
  chk_idle_high:
    assert property (tx_pin_oe_n_o |-> tx_pin_o) else $error("released line low");
  chk_start_width:
    assert property ($fell(tx_pin_o) |-> (!tx_pin_o || tx_pin_oe_n_o) [*8])
    else $error("start bit too short");
  // generator held in reset means the line cannot move
  chk_sleep_hold:
    assert property ((sleep_i && !tx_pin_oe_n_o) [*2] |=> tx_pin_oe_n_o || $stable(tx_pin_o))
    else $error("line moved in sleep");
  chk_abort_float:
    assert property (tx_off |-> tx_pin_oe_n_o && tx_pin_o) else $error("abort kept driving");
endmodule : ua_async_top_props

bind ua_async_top ua_async_top_props u_props (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .sleep_i(sleep_i),
  .rx_pin_i(rx_pin_i),
  .tx_pin_o(tx_pin_o),
  .tx_pin_oe_n_o(tx_pin_oe_n_o)
);

// ==== tb/ua_peer.sv ====
`timescale 1ns/1ns
module ua_peer (
  input  wire logic clk_i, // pacing clock
  input  wire logic tx_i,  // line from design, pulled up
  output logic      rx_o   // line into design
);
  int bit_clks = 64; // clocks per bit, 64 times (divisor + 1) for the divisor in use
  initial rx_o = 1'b1;

  // start low, data lsb first, stop, then one idle bit
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = 0; i < n + 3; i++) begin
      @(posedge clk_i);
      rx_o <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? stp : 1'b1;
      repeat (bit_clks - 1) @(posedge clk_i);
    end
  endtask : send

  // short low pulse, too brief to pass the vote
  task automatic pulse(input int n);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask : pulse

  // sample mid-bit; a bad start or stop spoils the word
  task automatic get(output logic [8:0] d, input int n);
    int   w;
    logic ok;
    w = 0;
    d = 9'h0;
    while (tx_i === 1'b1 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (bit_clks / 2) @(posedge clk_i);
    ok = (tx_i === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      d[i] = tx_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    if (!ok || tx_i !== 1'b1) d = 'x;
  endtask : get
endmodule : ua_peer

// ==== tb/ua_async_top_tb.sv ====
`timescale 1ns/1ns
module ua_async_top_tb
  import ua_pkg::*;
;
  logic       clk;     // system clock
  logic       rst_n;   // reset, active low
  logic       sleep;   // sleep request
  logic       line_tx; // tx line with pull-up
  logic       line_rx; // rx line from peer
  logic       tx_lvl;  // design tx level
  logic       tx_oe_n; // design drive, low
  ua_wb_req_s req;     // bus request
  ua_wb_rsp_s rsp;     // bus answer
  int         fails;   // mismatches
  int         n_tests; // comparisons
  logic [7:0] q;       // last read data
  logic [8:0] d1;      // received frame
  logic [8:0] d2;      // received frame

  // released line floats up to the pull-up
  assign line_tx = tx_oe_n ? 1'b1 : tx_lvl;
  always #20 clk = ~clk;

  ua_async_top DUT (
    .sys_clk_i(clk),
    .arst_n_i(rst_n),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .sleep_i(sleep),
    .rx_pin_i(line_rx),
    .tx_pin_o(tx_lvl),
    .tx_pin_oe_n_o(tx_oe_n)
  );
  ua_peer peer (.clk_i(clk), .tx_i(line_tx), .rx_o(line_rx));

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  // one classic cycle, held until ack is seen
  task automatic wb(input logic we, input logic [IDX_W-1:0] ix, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, {ix, 2'b00}, 4'hF, {24'h0, wd}};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    check({8'h0, rsp.ack}, 9'h001, "ack");
    q = rsp.dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [IDX_W-1:0] ix, input logic [7:0] e, input string m);
    wb(1'b0, ix, 8'h00);
    check({1'b0, q}, {1'b0, e}, m);
  endtask : rd

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // watchdog against a hung handshake or line
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sleep = 1'b0;
    req = '0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_FLAGS, 8'h02, "flags rst");
    rd(IDX_IRQEN, 8'h00, "irqen rst");
    rd(IDX_TXCTL, 8'h02, "txctl rst");
    rd(6'h00, 8'h00, "unmapped");
    wb(1'b1, IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, 8'h02, "flag kept");
    wb(1'b1, IDX_IRQEN, 8'h03);
    rd(IDX_IRQEN, 8'h03, "irqen rw");
    wb(1'b1, IDX_BAUD, 8'h00);
    wb(1'b1, IDX_RXCTL, 8'h90);
    wb(1'b1, IDX_TXCTL, 8'h20);
    rd(IDX_RXCTL, 8'h90, "rxctl");
    done("registers");
    fork
      begin
        peer.get(d1, 8);
        peer.get(d2, 8);
      end
      begin
        wb(1'b1, IDX_TXHOLD, 8'hA5);
        rd(IDX_FLAGS, 8'h02, "moved");
        rd(IDX_TXCTL, 8'h20, "busy");
        wb(1'b1, IDX_TXHOLD, 8'h3C);
        rd(IDX_FLAGS, 8'h00, "queued");
      end
    join
    check(d1, 9'h0A5, "frame one");
    check(d2, 9'h03C, "frame two");
    rd(IDX_FLAGS, 8'h02, "drained");
    done("back to back");
    wb(1'b1, IDX_TXCTL, 8'h61);
    fork
      peer.get(d1, 9);
      wb(1'b1, IDX_TXHOLD, 8'hC3);
    join
    check(d1, 9'h1C3, "nine bits");
    wb(1'b1, IDX_TXCTL, 8'h20);
    @(posedge clk);
    sleep <= 1'b1;
    wb(1'b1, IDX_TXHOLD, 8'h81);
    repeat (200) @(posedge clk);
    check({8'h0, line_tx}, 9'h001, "asleep");
    sleep <= 1'b0;
    peer.get(d1, 8);
    check(d1, 9'h081, "woken");
    done("nine bit and sleep");
    wb(1'b1, IDX_TXHOLD, 8'hF0);
    repeat (100) @(posedge clk);
    wb(1'b1, IDX_TXCTL, 8'h00);
    check({7'h0, tx_oe_n, tx_lvl}, 9'h003, "aborted");
    rd(IDX_TXCTL, 8'h02, "tx reset");
    wb(1'b1, IDX_TXCTL, 8'h30);
    check({8'h0, tx_oe_n}, 9'h001, "sync off");
    wb(1'b1, IDX_TXCTL, 8'h20);
    fork
      peer.get(d1, 8);
      wb(1'b1, IDX_TXHOLD, 8'h5A);
    join
    check(d1, 9'h05A, "re-enabled");
    done("abort");
    peer.send(9'h05A, 8, 1'b1);
    rd(IDX_FLAGS, 8'h03, "rx flag");
    rd(IDX_RXDATA, 8'h5A, "rx data");
    rd(IDX_FLAGS, 8'h02, "rx empty");
    peer.send(9'h001, 8, 1'b1);
    peer.send(9'h002, 8, 1'b0);
    peer.send(9'h003, 8, 1'b1);
    rd(IDX_RXCTL, 8'h92, "overrun");
    rd(IDX_RXDATA, 8'h01, "first kept");
    rd(IDX_RXCTL, 8'h96, "framing head");
    rd(IDX_RXDATA, 8'h02, "second kept");
    peer.send(9'h004, 8, 1'b1);
    rd(IDX_FLAGS, 8'h02, "blocked");
    wb(1'b1, IDX_RXCTL, 8'h80);
    wb(1'b1, IDX_RXCTL, 8'h90);
    rd(IDX_RXCTL, 8'h90, "cleared");
    wb(1'b1, IDX_RXCTL, 8'hA0);
    rd(IDX_RXCTL, 8'hA0, "single en");
    done("receive");
    wb(1'b1, IDX_RXCTL, 8'hD0);
    peer.send(9'h1A3, 9, 1'b1);
    rd(IDX_RXCTL, 8'hD1, "rx ninth");
    rd(IDX_RXDATA, 8'hA3, "rx nine data");
    peer.pulse(8);
    repeat (100) @(posedge clk);
    rd(IDX_FLAGS, 8'h02, "glitch");
    wb(1'b1, IDX_BAUD, 8'h01);
    peer.bit_clks = 128;
    fork
      peer.get(d1, 8);
      wb(1'b1, IDX_TXHOLD, 8'h96);
    join
    check(d1, 9'h096, "slow baud");
    done("nine rx and baud");
    wrap_up();
  end
endmodule : ua_async_top_tb
